/* pkg/port_glue_pkg.sv */
package port_glue_pkg;
  // Host task register address width and data width.
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int MCU_ADDR_W = 7;
  localparam int MCU_DATA_W = 8;
  // Soft reset command code seen on the command register.
  localparam logic [7:0] SOFT_RESET_CMD = 8'h08;
  localparam logic [2:0] COMMAND_REG_ADDR = 3'h7;
  // Soft reset pulse length in core clock cycles.
  localparam int SOFT_RESET_CYCLES = 32768;
  localparam int AUX_DIV = 512;
  localparam int AUX_HALF = AUX_DIV / 2;
  // Power-up reset hold time and its cycle count at 20 MHz.
  localparam int CHIP_RESET_NS = 1000;
  localparam int CLOCK_NS = 50;
  localparam int CHIP_RESET_CYCLES = (CHIP_RESET_NS + CLOCK_NS - 1) / CLOCK_NS;
  // Clock output mode codes.
  localparam logic [1:0] CLK_FULL = 2'h0;
  localparam logic [1:0] CLK_DIV = 2'h1;
  localparam logic [1:0] CLK_OFF = 2'h2;
  // System reset bit position in the system control write register.
  localparam int SYS_RESET_BIT = 7;
  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_WAIT = 3'h2,
    H_HOLD = 3'h4
  } host_state_t;
endpackage

/* pkg/port_glue_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface port_glue_if;
  import port_glue_pkg::*;
  logic command_block_select_n;
  logic control_block_select_n;
  logic [ADDR_W-1:0] host_addr;
  logic host_read_strobe_n;
  logic host_write_strobe_n;
  logic [DATA_W-1:0] host_wdata;
  logic [DATA_W-1:0] host_rdata;
  logic host_data_oe;
  logic dma_request;
  logic host_dma_ack_n;
  logic host_interrupt_request;
  logic wide_transfer_n;
  logic iordy;
  logic drive_present_n_o;
  logic drive_present_n_oe;
  logic diag_passed_n_o;
  logic diag_passed_n_oe;
  logic host_reset_n;
  // Open-drain wires resolve with a pull-up.
  wire drive_present_n = ~drive_present_n_oe | drive_present_n_o;
  wire diag_passed_n = ~diag_passed_n_oe | diag_passed_n_o;
  modport device (
    input command_block_select_n, control_block_select_n, host_addr,
    input host_read_strobe_n, host_write_strobe_n, host_wdata, host_dma_ack_n,
    input host_reset_n, drive_present_n, diag_passed_n,
    output host_rdata, host_data_oe, dma_request, host_interrupt_request,
    output wide_transfer_n, iordy, drive_present_n_o, drive_present_n_oe,
    output diag_passed_n_o, diag_passed_n_oe
  );
  modport host (
    output command_block_select_n, control_block_select_n, host_addr,
    output host_read_strobe_n, host_write_strobe_n, host_wdata, host_dma_ack_n,
    output host_reset_n,
    input host_rdata, host_data_oe, dma_request, host_interrupt_request,
    input wide_transfer_n, iordy, drive_present_n, diag_passed_n
  );
endinterface
`default_nettype wire

/* logic/ata_device_end.sv */
`timescale 1ns/1ps
`default_nettype none
module ata_device_end #(
  parameter int PULSE_CYCLES = port_glue_pkg::SOFT_RESET_CYCLES
) (
  // Core clock and reset.
  input wire logic clock,
  input wire logic rst,
  input wire logic chip_reset_n,
  // Host port.
  port_glue_if.device hp,
  // Configuration straps.
  input wire logic second_drive,
  input wire logic wide_capable,
  input wire logic [1:0] master_clock_mode,
  input wire logic [1:0] aux_clock_mode,
  // Local data path requests.
  input wire logic data_ready,
  input wire logic dma_pending,
  input wire logic host_irq_event,
  input wire logic diag_done,
  input wire logic buffer_busy,
  input wire logic [port_glue_pkg::DATA_W-1:0] read_data,
  output logic [port_glue_pkg::DATA_W-1:0] write_data,
  output logic write_strobe,
  output logic [port_glue_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_control_sel,
  output logic other_drive_present,
  output logic other_diag_passed,
  // Microcontroller port.
  input wire logic select_polarity,
  input wire logic mcu_select,
  input wire logic mcu_read_n,
  input wire logic mcu_write_n,
  input wire logic [port_glue_pkg::MCU_ADDR_W-1:0] mcu_addr,
  input wire logic [port_glue_pkg::MCU_DATA_W-1:0] mcu_data_i,
  output logic [port_glue_pkg::MCU_DATA_W-1:0] mcu_data_o,
  output logic mcu_data_oe,
  output logic mcu_wait_n,
  input wire logic mcu_irq_event,
  output logic mcu_irq_n,
  output logic ide_mcu_irq_n,
  input wire logic system_reset_bit,
  input wire logic [port_glue_pkg::MCU_DATA_W-1:0] mcu_reg_rdata,
  // Clock and reset outputs.
  output logic master_clock_out,
  output logic aux_clock_out,
  output logic reset_ic_drive_n_o,
  output logic reset_ic_drive_n_oe,
  output logic cpu_reset_out_n
);
  import port_glue_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] wdata;
    logic wstb;
    logic [ADDR_W-1:0] addr;
    logic ctl;
    logic [DATA_W-1:0] rdata;
    logic half;
    logic [8:0] aux_cnt;
    logic aux;
    logic [15:0] pulse_cnt;
    logic pulse;
    logic soft_irq;
    logic wr_d1;
    logic present;
    logic diag;
  } dev_state_t;

  dev_state_t s_q, s_d;
  logic host_sel;
  logic mcu_sel_act;

  // Either select reaches a register set; both at once are ignored.
  assign host_sel = hp.command_block_select_n ^ hp.control_block_select_n;

  always_comb begin
    s_d = s_q;
    s_d.wstb = 1'b0;
    s_d.wr_d1 = hp.host_write_strobe_n;
    s_d.rdata = read_data;
    // Latch the address at any selected access.
    if (host_sel) begin
      s_d.addr = hp.host_addr;
      s_d.ctl = ~hp.control_block_select_n;
    end
    // Write is taken on the rising edge of the strobe.
    if (host_sel && hp.host_write_strobe_n && !s_q.wr_d1) begin
      s_d.wdata = hp.host_wdata;
      s_d.wstb = 1'b1;
      // Soft reset starts a counted pulse.
      if (hp.command_block_select_n == 1'b0 && hp.host_addr == COMMAND_REG_ADDR &&
          hp.host_wdata[7:0] == SOFT_RESET_CMD) begin
        s_d.pulse = 1'b1;
        s_d.pulse_cnt = 16'(PULSE_CYCLES - 1);
        s_d.soft_irq = 1'b1;
      end
    end
    if (s_q.pulse && s_d.pulse_cnt == s_q.pulse_cnt) begin
      if (s_q.pulse_cnt == 16'h0000) begin
        s_d.pulse = 1'b0;
      end else begin
        s_d.pulse_cnt = s_q.pulse_cnt - 16'h0001;
      end
    end
    // The soft reset interrupt clears on a microcontroller read only when no soft reset pulse is starting or continuing into the next cycle.
    if (mcu_sel_act && !mcu_read_n && !s_d.pulse) begin
      s_d.soft_irq = 1'b0;
    end
    // Clock dividers run from the core clock.
    s_d.half = ~s_q.half;
    if (s_q.aux_cnt == 9'(AUX_HALF - 1)) begin
      s_d.aux_cnt = 9'h000;
      s_d.aux = ~s_q.aux;
    end else begin
      s_d.aux_cnt = s_q.aux_cnt + 9'h001;
    end
    s_d.present = hp.drive_present_n;
    s_d.diag = hp.diag_passed_n;
  end

  // Whole device state resets on rst or a low chip reset.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.wr_d1 <= 1'b1;
      s_q.present <= 1'b1;
      s_q.diag <= 1'b1;
    end else if (!chip_reset_n) begin
      s_q <= '0;
      s_q.wr_d1 <= 1'b1;
      s_q.present <= 1'b1;
      s_q.diag <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Host facing outputs.
  assign write_data = s_q.wdata;
  assign write_strobe = s_q.wstb;
  assign reg_addr = s_q.addr;
  assign reg_control_sel = s_q.ctl;
  assign hp.host_rdata = s_q.rdata;
  assign hp.host_data_oe = host_sel && !hp.host_read_strobe_n;
  assign hp.dma_request = dma_pending;
  assign hp.host_interrupt_request = host_irq_event;
  // Wide indication is dropped whenever a DMA acknowledge is active.
  assign hp.wide_transfer_n = ~(wide_capable && host_sel && hp.host_dma_ack_n);
  assign hp.iordy = data_ready;
  // Presence and diagnostics are driven only as the second drive.
  assign hp.drive_present_n_o = 1'b0;
  assign hp.drive_present_n_oe = second_drive;
  assign hp.diag_passed_n_o = 1'b0;
  assign hp.diag_passed_n_oe = second_drive && diag_done;
  assign other_drive_present = ~second_drive && ~s_q.present;
  assign other_diag_passed = ~second_drive && ~s_q.diag;

  // Select polarity: high strap means active-low select.
  assign mcu_sel_act = select_polarity ? ~mcu_select : mcu_select;
  assign mcu_data_o = mcu_reg_rdata;
  assign mcu_data_oe = mcu_sel_act && !mcu_read_n && mcu_write_n;
  // Wait stays low while the buffer cannot complete the access.
  assign mcu_wait_n = ~(mcu_sel_act && buffer_busy && (!mcu_read_n || !mcu_write_n));
  assign mcu_irq_n = ~(mcu_irq_event || s_q.soft_irq);
  assign ide_mcu_irq_n = ~host_irq_event;

  // Clock outputs are gated combinationally; a mode change may glitch.
  assign master_clock_out = (master_clock_mode == CLK_FULL) ? clock :
                            (master_clock_mode == CLK_DIV) ? s_q.half : 1'b0;
  assign aux_clock_out = (aux_clock_mode == CLK_FULL) ? clock :
                         (aux_clock_mode == CLK_DIV) ? s_q.aux : 1'b0;
  assign reset_ic_drive_n_o = 1'b0;
  assign reset_ic_drive_n_oe = system_reset_bit || !hp.host_reset_n;
  // Chip reset passes straight through; otherwise the soft pulse drives low.
  assign cpu_reset_out_n = chip_reset_n && !s_q.pulse;
endmodule
`default_nettype wire

/* logic/ata_host_end.sv */
`timescale 1ns/1ps
`default_nettype none
module ata_host_end (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Link to the device.
  port_glue_if.host hp,
  // User request side.
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_control,
  input wire logic [port_glue_pkg::ADDR_W-1:0] req_addr,
  input wire logic [port_glue_pkg::DATA_W-1:0] req_wdata,
  input wire logic host_reset_req,
  input wire logic dma_grant,
  output logic req_ready,
  output logic resp_valid,
  output logic [port_glue_pkg::DATA_W-1:0] resp_rdata,
  output logic device_irq,
  output logic device_dma_req
);
  import port_glue_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic cmd_n;
    logic ctl_n;
    logic rd_n;
    logic wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic resp;
    logic write;
  } host_reg_t;

  host_reg_t s_q, s_d;

  // Access: select and strobe, hold while ready low, then release.
  always_comb begin
    s_d = s_q;
    s_d.resp = 1'b0;
    case (s_q.st)
      H_IDLE: begin
        if (req_valid) begin
          s_d.cmd_n = req_control;
          s_d.ctl_n = ~req_control;
          s_d.addr = req_addr;
          s_d.wdata = req_wdata;
          s_d.write = req_write;
          s_d.rd_n = req_write;
          s_d.wr_n = ~req_write;
          s_d.st = H_WAIT;
        end
      end
      H_WAIT: begin
        // Stretch the strobe until the device reports ready.
        if (hp.iordy) begin
          s_d.rdata = hp.host_rdata;
          s_d.rd_n = 1'b1;
          s_d.wr_n = 1'b1;
          s_d.st = H_HOLD;
        end
      end
      H_HOLD: begin
        s_d.cmd_n = 1'b1;
        s_d.ctl_n = 1'b1;
        s_d.resp = 1'b1;
        s_d.st = H_IDLE;
      end
      default: s_d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= H_IDLE;
      s_q.cmd_n <= 1'b1;
      s_q.ctl_n <= 1'b1;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hp.command_block_select_n = s_q.cmd_n;
  assign hp.control_block_select_n = s_q.ctl_n;
  assign hp.host_addr = s_q.addr;
  assign hp.host_read_strobe_n = s_q.rd_n;
  assign hp.host_write_strobe_n = s_q.wr_n;
  assign hp.host_wdata = s_q.wdata;
  // Acknowledge is driven actively since the device has no pull-up.
  assign hp.host_dma_ack_n = ~(dma_grant && hp.dma_request);
  assign hp.host_reset_n = ~host_reset_req;
  assign req_ready = (s_q.st == H_IDLE);
  assign resp_valid = s_q.resp;
  assign resp_rdata = s_q.rdata;
  assign device_irq = hp.host_interrupt_request;
  assign device_dma_req = hp.dma_request;
endmodule
`default_nettype wire

/* bench/port_glue_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module port_glue_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Host link.
  input wire logic command_block_select_n,
  input wire logic control_block_select_n,
  input wire logic [port_glue_pkg::ADDR_W-1:0] host_addr,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic [port_glue_pkg::DATA_W-1:0] host_wdata,
  input wire logic host_dma_ack_n,
  input wire logic wide_transfer_n,
  input wire logic iordy
);
  import port_glue_pkg::*;
  // Every check here lives in the one core clock domain.
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic sel;
  logic stb;
  // Any select or strobe low marks an access in flight.
  assign sel = !command_block_select_n || !control_block_select_n;
  assign stb = !host_read_strobe_n || !host_write_strobe_n;
  a_select_exclusive: assert property (command_block_select_n || control_block_select_n)
    else $error("both selects low");
  a_strobe_selected: assert property (stb |-> sel)
    else $error("strobe without select");
  a_ready_ends_strobe: assert property (stb && iordy |=> !stb)
    else $error("strobe kept after ready");
  a_busy_holds_read: assert property (!host_read_strobe_n && !iordy |=> !host_read_strobe_n)
    else $error("read ended before ready");
  a_select_outlives: assert property ($rose(host_read_strobe_n) || $rose(host_write_strobe_n)
    |-> sel)
    else $error("select dropped with strobe");
  a_wide_off_dma: assert property (!host_dma_ack_n |-> wide_transfer_n)
    else $error("wide during dma");
  a_wdata_steady: assert property (!host_write_strobe_n && !$past(host_write_strobe_n)
    |-> $stable(host_wdata))
    else $error("write data moved");
  a_addr_steady: assert property (sel && $past(sel) |-> $stable(host_addr))
    else $error("address moved");
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import port_glue_pkg::*;
  localparam int PW = 16;
  logic clock = 0, rst = 1, chip_reset_n = 1, second_drive = 0, wide_capable = 1;
  logic [1:0] master_clock_mode = 2'h2, aux_clock_mode = 2'h2;
  logic data_ready = 1, dma_pending = 0, host_irq_event = 0, diag_done = 0, buffer_busy = 0;
  logic [15:0] read_data = 16'hBEEF, write_data, req_wdata = 0, resp_rdata, wd;
  logic write_strobe, reg_control_sel, other_drive_present, other_diag_passed, wc;
  logic [2:0] reg_addr, req_addr = 0, wa;
  logic select_polarity = 1, mcu_select = 1, mcu_read_n = 1, mcu_write_n = 1;
  logic [6:0] mcu_addr = 0;
  logic [7:0] mcu_data_i = 0, mcu_data_o, mcu_reg_rdata = 8'hA5;
  logic mcu_data_oe, mcu_wait_n, mcu_irq_event = 0, mcu_irq_n, ide_mcu_irq_n;
  logic system_reset_bit = 0, master_clock_out, aux_clock_out, reset_ic_drive_n_oe;
  logic cpu_reset_out_n, req_valid = 0, req_write = 0, req_control = 0, host_reset_req = 0;
  logic dma_grant = 0, req_ready, resp_valid, device_irq, device_dma_req;
  int n_mismatch = 0, n_compared = 0, cyc = 0, lowcnt = 0;
  port_glue_if lnk();
  ata_device_end #(.PULSE_CYCLES(PW)) i_ata_device_end (.clock, .rst, .chip_reset_n, .hp(lnk),
    .second_drive, .wide_capable, .master_clock_mode, .aux_clock_mode, .data_ready,
    .dma_pending, .host_irq_event, .diag_done, .buffer_busy, .read_data, .write_data,
    .write_strobe, .reg_addr, .reg_control_sel, .other_drive_present, .other_diag_passed,
    .select_polarity, .mcu_select, .mcu_read_n, .mcu_write_n, .mcu_addr, .mcu_data_i,
    .mcu_data_o, .mcu_data_oe, .mcu_wait_n, .mcu_irq_event, .mcu_irq_n, .ide_mcu_irq_n,
    .system_reset_bit, .mcu_reg_rdata, .master_clock_out, .aux_clock_out,
    .reset_ic_drive_n_o(), .reset_ic_drive_n_oe, .cpu_reset_out_n);
  ata_host_end i_ata_host_end (.clock, .rst, .hp(lnk), .req_valid, .req_write, .req_control,
    .req_addr, .req_wdata, .host_reset_req, .dma_grant, .req_ready, .resp_valid, .resp_rdata,
    .device_irq, .device_dma_req);
  port_glue_chk i_port_glue_chk (.clock, .rst, .command_block_select_n(lnk.command_block_select_n),
    .control_block_select_n(lnk.control_block_select_n), .host_addr(lnk.host_addr),
    .host_read_strobe_n(lnk.host_read_strobe_n), .host_write_strobe_n(lnk.host_write_strobe_n),
    .host_wdata(lnk.host_wdata), .host_dma_ack_n(lnk.host_dma_ack_n),
    .wide_transfer_n(lnk.wide_transfer_n), .iordy(lnk.iordy));
  // Half period of 25 ns gives the 20 MHz core clock.
  always #25 clock = ~clock;
  // Cycle count for the time limit, and the length of the soft reset pulse.
  always @(posedge clock) begin
    cyc++;
    if (!cpu_reset_out_n) lowcnt++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One host access, waiting a bounded time for the response pulse.
  task automatic hx(input logic w, input logic c, input logic [2:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(negedge clock);
    {req_valid, req_write, req_control, req_addr, req_wdata} = {1'b1, w, c, a, d};
    @(negedge clock);
    req_valid = 0;
    while (resp_valid !== 1'b1 && k < 40) begin
      @(negedge clock);
      k++;
    end
    chk("resp_valid", {15'h0, resp_valid}, 16'h1);
    // The write strobe stands in the same cycle as the response, so its payload is taken here.
    if (w) chk("wr_strobe", {15'h0, write_strobe}, 16'h1);
    if (write_strobe === 1'b1) {wa, wd, wc} = {reg_addr, write_data, reg_control_sel};
    @(negedge clock);
  endtask
  task automatic t_soft();
    lowcnt = 0;
    hx(1, 0, COMMAND_REG_ADDR, {8'h00, SOFT_RESET_CMD});
    chk("reg_addr", {13'h0, wa}, {13'h0, COMMAND_REG_ADDR});
    chk("ctl_sel", {15'h0, wc}, 16'h0);
    chk("wr_data", wd, 16'h0008);
    repeat (PW + 8) @(negedge clock);
    chk("pulse", lowcnt[15:0], 16'(PW));
    chk("soft_irq", {15'h0, mcu_irq_n}, 16'h0);
    {mcu_select, mcu_read_n, buffer_busy} = 3'b001;
    #1 chk("wait", {15'h0, mcu_wait_n}, 16'h0);
    chk("mcu_oe", {15'h0, mcu_data_oe}, 16'h1);
    chk("mcu_data", {8'h0, mcu_data_o}, 16'h00A5);
    @(negedge clock);
    select_polarity = 0;
    #1 chk("mcu_oe_pol", {15'h0, mcu_data_oe}, 16'h0);
    {mcu_read_n, buffer_busy, select_polarity, mcu_select} = 4'b1010;
    @(negedge clock);
    chk("irq_clr", {15'h0, mcu_irq_n}, 16'h1);
    $display("test soft reset done");
  endtask
  task automatic t_ctrl();
    hx(1, 1, 3'h6, 16'h00C3);
    chk("ctl_sel", {15'h0, wc}, 16'h1);
    data_ready = 0;
    fork
      hx(0, 0, 3'h0, 16'h0);
      begin
        repeat (5) @(negedge clock);
        data_ready = 1;
      end
    join
    chk("rdata", resp_rdata, 16'hBEEF);
    $display("test control and slow read done");
  endtask
  task automatic t_lines();
    {second_drive, diag_done, dma_pending, host_irq_event, mcu_irq_event} = 5'h1F;
    repeat (2) @(negedge clock);
    chk("present", {15'h0, lnk.drive_present_n}, 16'h0);
    chk("diag", {15'h0, lnk.diag_passed_n}, 16'h0);
    chk("dma_req", {15'h0, device_dma_req}, 16'h1);
    chk("host_irq", {15'h0, device_irq}, 16'h1);
    chk("ide_irq", {15'h0, ide_mcu_irq_n}, 16'h0);
    chk("mcu_irq", {15'h0, mcu_irq_n}, 16'h0);
    {second_drive, dma_grant, system_reset_bit} = 3'b011;
    repeat (2) @(negedge clock);
    chk("ack", {15'h0, lnk.host_dma_ack_n}, 16'h0);
    chk("wide", {15'h0, lnk.wide_transfer_n}, 16'h1);
    chk("other", {15'h0, other_drive_present}, 16'h0);
    chk("other_diag", {15'h0, other_diag_passed}, 16'h0);
    chk("ic_bit", {15'h0, reset_ic_drive_n_oe}, 16'h1);
    {diag_done, dma_pending, host_irq_event, mcu_irq_event, dma_grant} = 5'h0;
    {system_reset_bit, host_reset_req} = 2'b01;
    repeat (2) @(negedge clock);
    chk("ic_host", {15'h0, reset_ic_drive_n_oe}, 16'h1);
    host_reset_req = 0;
    repeat (2) @(negedge clock);
    chk("ic_off", {15'h0, reset_ic_drive_n_oe}, 16'h0);
    chip_reset_n = 0;
    #1 chk("cpu_rst", {15'h0, cpu_reset_out_n}, 16'h0);
    @(negedge clock);
    chip_reset_n = 1;
    $display("test pins done");
  endtask
  // Counting edges over a fixed span avoids depending on the divider's phase.
  task automatic t_clocks(input logic [1:0] m, input int span, input int em, input int ea);
    int mc;
    int ac;
    logic pm;
    logic pa;
    {mc, ac, master_clock_mode, aux_clock_mode} = {32'h0, 32'h0, m, m};
    repeat (4) @(negedge clock);
    {pm, pa} = {master_clock_out, aux_clock_out};
    repeat (span) begin
      @(negedge clock);
      mc += int'(master_clock_out !== pm);
      ac += int'(aux_clock_out !== pa);
      {pm, pa} = {master_clock_out, aux_clock_out};
    end
    chk("mck", mc[15:0], em[15:0]);
    chk("aux", ac[15:0], ea[15:0]);
    $display("test clock mode done");
  endtask
  // Full rate mode passes the core clock, so it is seen high after a rising edge.
  task automatic t_full();
    {master_clock_mode, aux_clock_mode} = {CLK_FULL, CLK_FULL};
    @(posedge clock);
    #1 chk("clk_hi", {14'h0, master_clock_out, aux_clock_out}, 16'h0003);
    @(negedge clock);
    #1 chk("clk_lo", {14'h0, master_clock_out, aux_clock_out}, 16'h0000);
    $display("test full clock done");
  endtask
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clock);
    rst = 0;
    t_soft();
    t_ctrl();
    t_lines();
    t_clocks(CLK_DIV, 1024, 1024, 4);
    t_clocks(CLK_OFF, 64, 0, 0);
    t_full();
    finish_test();
  end
endmodule
`default_nettype wire
